// ==== logic/gpib_defines.svh ====
// Register offsets, field positions and bus command codes of the GPIB status block
// ============================================================================
// Summary of operation
// - Host command bytes go out in issue order
// - Any 8-bit command value is sent unchanged
// - Commands sent only while active controller
// - Nonzero low byte to reset register resets all
// - Interrupt/DMA status byte layout, bits 3:2 zero
// - Serial poll byte, bit 6 requests service
// - Parallel poll byte bit n drives line n+1
// - Role status: system, active, bit 5 zero
// - Own 5-bit address written and read back
// - 16-bit event word with documented flags
// - Attention held for whole command byte
// - Decode listen, talk, unlisten, untalk codes
`ifndef GPIB_DEFINES_SVH
`define GPIB_DEFINES_SVH

// Read side (status) and write side (control) offsets
`define SR_CARD_ID 4'h0
`define SR_IRQ     4'h1
`define SR_ROLE    4'h3
`define SR_EVENTS  4'h4
`define SR_XFER    4'h5
`define CR_RESET   4'h0
`define CR_SPOLL   4'h1
`define CR_PPOLL   4'h2
`define CR_ADDR    4'h3
`define CR_CMD     4'h5
`define CR_IRQ     4'h6
`define CR_ROLE    4'h7

// Field positions
`define ROLE_SYS 7
`define ROLE_ACT 6
`define SPR_RQS  6

// Event word bit positions
`define EV_ACT  15
`define EV_PPC  14
`define EV_MTA  13
`define EV_MLA  12
`define EV_EOI  11
`define EV_SERIAL_POLL 10
`define EV_REM  9
`define EV_ADDR 8
`define EV_GET  7
`define EV_HSE  6
`define EV_UUC  5
`define EV_SEC  4
`define EV_DCL  3
`define EV_UAC  2
`define EV_SRQ  1
`define EV_IFC  0

// Bus command codes (7 bits) and group selectors (bits 6:5 or 6:4)
`define C_GTL 7'h01
`define C_SDC 7'h04
`define C_PPC 7'h05
`define C_GET 7'h08
`define C_TCT 7'h09
`define C_LLO 7'h11
`define C_DCL 7'h14
`define C_PPU 7'h15
`define C_SPE 7'h18
`define C_SPD 7'h19
`define C_UNL 7'h3f
`define C_UNT 7'h5f
`define C_DEL 7'h7f
`define G_LAG 2'h1
`define G_TAG 2'h2
`define G_SCG 2'h3
`define G_ACG 3'h0
`define G_UCG 3'h1

// Data settle time before the valid strobe
`define CLK_NS     100
`define SETTLE_NS  500
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== logic/gpib_pkg.sv ====
// Types shared by the GPIB status and control block
package gpib_pkg;

  // Source handshake of the byte sender
  typedef enum logic [1:0] {
    TX_IDLE,
    TX_SETTLE,
    TX_VALID
  } tx_state_e;

  // Acceptor handshake of the byte receiver
  typedef enum logic {
    ACC_RDY,
    ACC_HOLD
  } acc_state_e;

  // Whole state of the block
  typedef struct packed {
    logic        int_en;
    logic [1:0]  int_lvl;
    logic [1:0]  dma_en;
    logic [7:0]  spr;
    logic [7:0]  ppr;
    logic [4:0]  my_addr;
    logic        sys_ctl;
    logic        act_ctl;
    logic [15:0] events;
    logic        serial_poll_active_state;
    logic        listen;
    logic        talk;
    logic        sp_sent;
    logic        refused;
    tx_state_e   tx;
    logic [7:0]  tx_byte;
    logic        tx_atn;
    logic [3:0]  cnt;
    acc_state_e  acc;
    logic [7:0]  dio;
    logic        dio_oe;
    logic        atn;
    logic        dav;
    logic        nrfd;
    logic        ndac;
    logic        srq;
    logic        ifc_q;
    logic        ren_q;
    logic        srq_q;
    logic [15:0] rdata;
  } state_s;

endpackage

// ==== logic/gpib_status_control.sv ====
// GPIB interface status/control registers, command sender and bus acceptor
//
// The implementer's own choice: the address-and-strobe port.
`include "gpib_defines.svh"

module gpib_status_control #(
  parameter logic [6:0] CARD_ID = 7'h2a // Arbitrary identification value
) (
  input  wire logic        clock,    // 10 MHz clock
  input  wire logic        rst_n,    // Async reset, active low
  input  wire logic [3:0]  addr,     // Register number
  input  wire logic [15:0] wdata,    // Write data
  input  wire logic        wr,       // Write strobe
  input  wire logic        rd,       // Read strobe
  output logic      [15:0] rdata,    // Read data, cycle after rd
  input  wire logic [7:0]  dio_in,   // Data lines, true logic
  output logic      [7:0]  dio_out,  // Data lines driven
  output logic             dio_oe,   // Data lines enable
  input  wire logic        atn_in,   // Attention seen
  output logic             atn_out,  // Attention driven
  output logic             atn_oe,   // Attention enable
  input  wire logic        dav_in,   // Data valid seen
  output logic             dav_out,  // Data valid driven
  output logic             dav_oe,   // Data valid enable
  input  wire logic        nrfd_in,  // Not ready seen
  output logic             nrfd_out, // Not ready driven
  output logic             nrfd_oe,  // Not ready enable
  input  wire logic        ndac_in,  // Not accepted seen
  output logic             ndac_out, // Not accepted driven
  output logic             ndac_oe,  // Not accepted enable
  input  wire logic        eoi_in,   // End or identify seen
  input  wire logic        srq_in,   // Service request seen
  output logic             srq_out,  // Service request driven
  output logic             srq_oe,   // Service request enable
  input  wire logic        ifc_in,   // Interface clear seen
  input  wire logic        ren_in    // Remote enable seen
);

  // ==========================================================================
  // Reset release
  logic rst_q1;
  logic rst_sync;

  // Two-stage release keeps recovery timing clean
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_q1   <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_q1   <= 1'b1;
      rst_sync <= rst_q1;
    end
  end

  // ==========================================================================
  // State
  gpib_pkg::state_s s;
  gpib_pkg::state_s n;
  logic [15:0]      ev;
  logic [6:0]       b;
  logic             part;
  logic             ppoll;
  logic             cmd_wr;

  assign b      = dio_in[6:0];
  assign cmd_wr = wr && addr == `CR_CMD;
  assign part   = !s.act_ctl && (atn_in || s.listen);
  assign ppoll  = atn_in && eoi_in && !s.act_ctl;

  // Next state of everything
  always_comb begin
    n  = s;
    ev = '0;

    // Host register writes
    if (wr) begin
      unique case (addr)
        `CR_SPOLL: n.spr = wdata[7:0];
        `CR_PPOLL: n.ppr = wdata[7:0];
        `CR_ADDR:  n.my_addr = wdata[4:0];
        `CR_IRQ: begin
          n.int_en  = wdata[7];
          n.int_lvl = wdata[5:4];
          n.dma_en  = wdata[1:0];
        end
        `CR_ROLE: begin
          n.sys_ctl = wdata[`ROLE_SYS];
          n.act_ctl = wdata[`ROLE_ACT];
        end
        default: ;
      endcase
    end

    // Host reads of status registers, answered next cycle
    n.rdata = '0;
    if (rd) begin
      unique case (addr)
        `SR_CARD_ID: n.rdata = {8'h00, 1'b0, CARD_ID};
        `SR_IRQ:     n.rdata = {8'h00, s.int_en, 1'b0, s.int_lvl,
                                2'b00, s.dma_en};
        `SR_ROLE:    n.rdata = {8'h00, s.sys_ctl, s.act_ctl, 1'b0,
                                s.my_addr};
        `SR_EVENTS:  n.rdata = s.events;
        `SR_XFER:    n.rdata = {10'h000, s.tx != gpib_pkg::TX_IDLE,
                                s.refused, s.serial_poll_active_state, s.talk, s.listen,
                                s.sp_sent};
        default:     n.rdata = '0;
      endcase
      if (addr == `SR_XFER) begin
        n.refused = 1'b0;
      end
    end

    // Line edges seen on the bus
    n.ifc_q = ifc_in;
    n.ren_q = ren_in;
    n.srq_q = srq_in;
    if (ifc_in && !s.ifc_q) begin
      ev[`EV_IFC] = 1'b1;
      n.listen    = 1'b0;
      n.talk      = 1'b0;
      n.serial_poll_active_state = 1'b0;
      if (!s.sys_ctl) begin
        n.act_ctl = 1'b0;
      end
    end
    if (ren_in != s.ren_q) begin
      ev[`EV_REM] = 1'b1;
    end
    if (srq_in && !s.srq_q && s.act_ctl) begin
      ev[`EV_SRQ] = 1'b1;
    end
    if (atn_in) begin
      n.sp_sent = 1'b0;
    end

    // Acceptor handshake; attention bytes are decoded as commands
    if (!part) begin
      n.acc = gpib_pkg::ACC_RDY;
    end else begin
      unique case (s.acc)
        gpib_pkg::ACC_RDY: begin
          if (dav_in) begin
            n.acc = gpib_pkg::ACC_HOLD;
            if (!atn_in) begin
              ev[`EV_EOI] = eoi_in;
            end else if (b[6:5] == `G_LAG && b != `C_UNL) begin
              if (b[4:0] == s.my_addr) begin
                n.listen       = 1'b1;
                ev[`EV_MLA]    = 1'b1;
                ev[`EV_ADDR]   = !s.listen;
              end
            end else if (b == `C_UNL) begin
              n.listen     = 1'b0;
              ev[`EV_ADDR] = s.listen;
            end else if (b[6:5] == `G_TAG && b != `C_UNT) begin
              n.talk       = b[4:0] == s.my_addr;
              ev[`EV_MTA]  = n.talk;
              ev[`EV_ADDR] = n.talk != s.talk;
            end else if (b == `C_UNT) begin
              n.talk       = 1'b0;
              ev[`EV_ADDR] = s.talk;
            end else if (b[6:5] == `G_SCG) begin
              ev[`EV_SEC] = b != `C_DEL && (s.listen || s.talk);
            end else begin
              unique case (b)
                `C_GTL: ev[`EV_REM] = s.listen;
                `C_SDC: ev[`EV_DCL] = s.listen;
                `C_PPC: ev[`EV_PPC] = s.listen;
                `C_GET: ev[`EV_GET] = s.listen;
                `C_DCL: ev[`EV_DCL] = 1'b1;
                `C_SPE: begin
                  n.serial_poll_active_state = 1'b1;
                  ev[`EV_SERIAL_POLL]        = !s.serial_poll_active_state;
                end
                `C_SPD: begin
                  n.serial_poll_active_state = 1'b0;
                  ev[`EV_SERIAL_POLL]        = s.serial_poll_active_state;
                end
                `C_TCT: begin
                  n.act_ctl     = s.talk;
                  ev[`EV_ACT]   = s.talk;
                end
                `C_LLO, `C_PPU: ;
                default: begin
                  ev[`EV_UAC] = b[6:4] == `G_ACG;
                  ev[`EV_UUC] = b[6:4] == `G_UCG;
                end
              endcase
            end
          end
        end
        gpib_pkg::ACC_HOLD: begin
          if (!dav_in) begin
            n.acc = gpib_pkg::ACC_RDY;
          end
        end
      endcase
    end
    n.nrfd = part && n.acc == gpib_pkg::ACC_HOLD;
    n.ndac = part && n.acc == gpib_pkg::ACC_RDY;

    // Source handshake; one byte at a time, no queue behind it
    unique case (s.tx)
      gpib_pkg::TX_IDLE: begin
        if (cmd_wr) begin
          if (s.act_ctl) begin
            n.tx      = gpib_pkg::TX_SETTLE;
            n.tx_byte = wdata[7:0];
            n.tx_atn  = 1'b1;
            n.cnt     = 4'(`SETTLE_CYC);
          end else begin
            n.refused = 1'b1;
          end
        end else if (s.serial_poll_active_state && s.talk && !s.act_ctl && !atn_in
                     && !s.sp_sent) begin
          n.tx      = gpib_pkg::TX_SETTLE;
          n.tx_byte = s.spr;
          n.tx_atn  = 1'b0;
          n.cnt     = 4'(`SETTLE_CYC);
        end
      end
      gpib_pkg::TX_SETTLE: begin
        // Built on n so that a status read still clears the flag while busy
        n.refused = n.refused || cmd_wr;
        if (s.cnt != 4'h0) begin
          n.cnt = s.cnt - 4'h1;
        end else if (!nrfd_in && !ndac_in) begin
          // Nobody holds the handshake: no acceptor present
          ev[`EV_HSE] = 1'b1;
          n.tx        = gpib_pkg::TX_IDLE;
        end else if (!nrfd_in) begin
          n.tx = gpib_pkg::TX_VALID;
        end
      end
      gpib_pkg::TX_VALID: begin
        n.refused = n.refused || cmd_wr;
        if (!ndac_in) begin
          n.tx      = gpib_pkg::TX_IDLE;
          n.sp_sent = !s.tx_atn;
        end
      end
      default: n.tx = gpib_pkg::TX_IDLE;
    endcase
    if (n.act_ctl != s.act_ctl && n.act_ctl) begin
      ev[`EV_ACT] = 1'b1;
    end

    // Bus drivers; attention stays up for the whole byte
    n.dav    = n.tx == gpib_pkg::TX_VALID;
    n.atn    = n.tx != gpib_pkg::TX_IDLE && n.tx_atn;
    n.dio_oe = n.tx != gpib_pkg::TX_IDLE || ppoll;
    n.dio    = n.tx != gpib_pkg::TX_IDLE ? n.tx_byte
             : (ppoll ? s.ppr : 8'h00);
    n.srq    = n.spr[`SPR_RQS] && !n.act_ctl;

    // Events stick until read; a new event wins over the read clear
    if (rd && addr == `SR_EVENTS) begin
      n.events = '0;
    end
    n.events = n.events | ev;

    // A write with a nonzero low byte to the reset register clears everything
    if (wr && addr == `CR_RESET && wdata[7:0] != 8'h00) begin
      n = '0;
    end
  end

  // Single state register
  always_ff @(posedge clock or negedge rst_sync) begin
    if (!rst_sync) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ==========================================================================
  // Outputs, all straight from the state register
  assign rdata    = s.rdata;
  assign dio_out  = s.dio;
  assign dio_oe   = s.dio_oe;
  assign atn_out  = s.atn;
  assign atn_oe   = s.atn;
  assign dav_out  = s.dav;
  assign dav_oe   = s.dav;
  assign nrfd_out = s.nrfd;
  assign nrfd_oe  = s.nrfd;
  assign ndac_out = s.ndac;
  assign ndac_oe  = s.ndac;
  assign srq_out  = s.srq;
  assign srq_oe   = s.srq;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_sync);

  soft_reset_a: assert property (
    wr && addr == `CR_RESET && wdata[7:0] != 8'h00
    |=> s.spr == 8'h00 && s.my_addr == 5'h00 && !s.act_ctl)
    else $error("reset write did not clear state");

  cmd_refused_a: assert property (
    cmd_wr && !s.act_ctl && s.tx == gpib_pkg::TX_IDLE
    |=> s.refused && s.tx == gpib_pkg::TX_IDLE && !atn_out)
    else $error("command sent without active controller role");

  cmd_value_a: assert property (
    cmd_wr && s.act_ctl && s.tx == gpib_pkg::TX_IDLE
    |=> dio_out == $past(wdata[7:0]) && dio_oe && atn_out)
    else $error("command byte not placed on data lines");

  atn_hold_a: assert property (
    atn_out && dav_out |=> atn_out || !dav_out)
    else $error("attention dropped during command byte");

  ppoll_drive_a: assert property (
    ppoll && !wr && s.tx == gpib_pkg::TX_IDLE
    |=> dio_oe && dio_out == $past(s.ppr))
    else $error("parallel poll byte not driven");

  srq_level_a: assert property (
    !wr ##1 !wr ##1 !s.act_ctl |-> srq_out == $past(s.spr[`SPR_RQS], 2))
    else $error("service request not following poll byte");

  role_read_a: assert property (
    rd && addr == `SR_ROLE
    |=> rdata[5] == 1'b0 && rdata[4:0] == $past(s.my_addr)
        && rdata[7] == $past(s.sys_ctl))
    else $error("role and address read wrong");

  irq_read_a: assert property (
    rd && addr == `SR_IRQ
    |=> rdata[3:2] == 2'b00 && rdata[7] == $past(s.int_en)
        && rdata[1:0] == $past(s.dma_en))
    else $error("interrupt status read wrong");

  events_stick_a: assert property (
    !(rd && addr == `SR_EVENTS) && !wr
    |=> (s.events & $past(s.events)) == $past(s.events))
    else $error("event bit lost before read");

  listen_decode_a: assert property (
    part && s.acc == gpib_pkg::ACC_RDY && atn_in && dav_in && !wr
    && b == {`G_LAG, s.my_addr} && s.my_addr != 5'h1f
    |=> s.listen && s.events[`EV_MLA])
    else $error("own listen address not decoded");

endmodule

// ==== testbench/gpib_instrument_model.sv ====
// Bus instrument model: acceptor handshake on the far side of the interface
module gpib_instrument_model (
  input  wire logic       clock,    // Bus clock
  input  wire logic       en,       // Take part in handshakes
  input  wire logic [3:0] hold_cyc, // Busy cycles per byte
  input  wire logic [7:0] dio,      // Data lines seen
  input  wire logic       atn,      // Attention seen
  input  wire logic       dav,      // Data valid seen
  output logic            nrfd,     // Not ready driven
  output logic            ndac,     // Not accepted driven
  output logic      [7:0] got_byte, // Last byte taken
  output logic            got_atn,  // Attention with that byte
  output logic            atn_slip, // Attention moved in mid-byte
  output int              got_cnt   // Bytes taken
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] st;
  logic [3:0] cnt;

  // ==========================================================
  // Acceptor
  // Released lines fall to the pull-up level, which reads false
  initial begin
    {nrfd, ndac, atn_slip, st, cnt, got_byte, got_atn} = '0;
    got_cnt = 0;
  end

  // Three-wire acceptor; a slow instrument keeps the byte hold_cyc cycles
  always @(posedge clock) begin
    if (st != 2'h0 && dav && atn !== got_atn) begin
      atn_slip <= 1'b1;
    end
    if (!en) begin
      {nrfd, ndac, st} <= '0;
    end else begin
      case (st)
        2'h0: begin
          nrfd <= 1'b0;
          ndac <= 1'b1;
          if (dav && ndac) begin
            got_byte <= dio;
            got_atn  <= atn;
            nrfd     <= 1'b1;
            cnt      <= hold_cyc;
            st       <= 2'h1;
          end
        end
        2'h1: begin
          if (cnt == 4'h0) begin
            ndac <= 1'b0;
            st   <= 2'h2;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: begin
          if (!dav) begin
            ndac    <= 1'b1;
            nrfd    <= 1'b0;
            got_cnt <= got_cnt + 1;
            st      <= 2'h0;
          end
        end
      endcase
    end
  end
endmodule

// ==== testbench/gpib_interface_status_control_tb.sv ====
// Self-checking bench of the GPIB status and control block
`include "gpib_defines.svh"

module gpib_interface_status_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst_n, wr, rd, tb_atn, tb_dav, tb_eoi, pm_en, tb_ifc, tb_ren;
  logic [3:0]  addr, pm_hold;
  logic [15:0] wdata, rdata;
  logic [7:0]  dio_out, tb_dio, pm_byte;
  logic        dio_oe, atn_out, atn_oe, dav_out, dav_oe, nrfd_out, nrfd_oe;
  logic        ndac_out, ndac_oe, srq_out, srq_oe, pm_nrfd, pm_ndac, pm_atn, pm_slip;
  int          pm_cnt, failures, cmp_count, n, c0;
  wire  [7:0]  dio_w = (dio_oe ? dio_out : 8'h00) | tb_dio;
  wire         atn_w = (atn_oe & atn_out) | tb_atn;
  wire         dav_w = (dav_oe & dav_out) | tb_dav;
  wire         nrfd_w = (nrfd_oe & nrfd_out) | pm_nrfd;
  wire         ndac_w = (ndac_oe & ndac_out) | pm_ndac;
  logic [7:0]  cmds [6] = '{8'h00, 8'h3f, 8'h5f, 8'h21, 8'h55, 8'hff};

  gpib_status_control #(.CARD_ID(7'h15)) dut ( // Arbitrary identification value
    .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .dio_in(dio_w), .dio_out(dio_out), .dio_oe(dio_oe),
    .atn_in(atn_w), .atn_out(atn_out), .atn_oe(atn_oe), .dav_in(dav_w),
    .dav_out(dav_out), .dav_oe(dav_oe), .nrfd_in(nrfd_w), .nrfd_out(nrfd_out),
    .nrfd_oe(nrfd_oe), .ndac_in(ndac_w), .ndac_out(ndac_out), .ndac_oe(ndac_oe),
    .eoi_in(tb_eoi), .srq_in(srq_oe & srq_out), .srq_out(srq_out), .srq_oe(srq_oe),
    .ifc_in(tb_ifc), .ren_in(tb_ren));

  gpib_instrument_model pm (.clock(clock), .en(pm_en), .hold_cyc(pm_hold), .dio(dio_w),
    .atn(atn_w), .dav(dav_w), .nrfd(pm_nrfd), .ndac(pm_ndac), .got_byte(pm_byte),
    .got_atn(pm_atn), .atn_slip(pm_slip), .got_cnt(pm_cnt));

  // ==========================================================
  // Shared tasks
  // Clock at 10 MHz
  always #50 clock = ~clock;

  task automatic wrap_up();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A wait that runs out of its bound ends the run
  task automatic hang(input int k);
    if (k >= 300) begin
      failures++;
      wrap_up();
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clock);
    wr <= 1'b0;
  endtask

  // Data are sampled in the single cycle that they stand
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clock);
    {rd, addr} <= {1'b1, a};
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
    check(rdata & m, e);
  endtask

  // Another controller sends one attention byte to the block
  task automatic send_atn(input logic [7:0] b);
    @(posedge clock);
    {tb_atn, tb_dio} <= {1'b1, b};
    repeat (5) @(posedge clock);
    for (n = 0; n < 300 && !(nrfd_w == 1'b0 && ndac_w == 1'b1); n++) @(posedge clock);
    hang(n);
    tb_dav <= 1'b1;
    for (n = 0; n < 300 && ndac_w; n++) @(posedge clock);
    hang(n);
    @(posedge clock);
    tb_dav <= 1'b0;
    for (n = 0; n < 300 && !ndac_w; n++) @(posedge clock);
    hang(n);
    tb_dio <= 8'h00;
  endtask

  task automatic wait_got(input int c);
    for (n = 0; n < 300 && pm_cnt == c; n++) @(posedge clock);
    hang(n);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_registers();
    rd_chk(`SR_CARD_ID, 16'h0015, 16'hffff);
    rd_chk(`SR_ROLE, 16'h0000, 16'hffff);
    rd_chk(`SR_EVENTS, 16'h0000, 16'hffff);
    rd_chk(4'hf, 16'h0000, 16'hffff);
    wr_reg(`CR_IRQ, 16'h00ff);
    rd_chk(`SR_IRQ, 16'h00b3, 16'hffff);
    wr_reg(`CR_IRQ, 16'h004d);
    rd_chk(`SR_IRQ, 16'h0001, 16'hffff);
    wr_reg(`CR_ROLE, 16'h00ff);
    wr_reg(`CR_ADDR, 16'h00ff);
    rd_chk(`SR_ROLE, 16'h00df, 16'hffff);
    wr_reg(`CR_ADDR, 16'h000e);
    rd_chk(`SR_ROLE, 16'h00ce, 16'hffff);
  endtask

  // Each single bit resets; bits above the byte do not
  task automatic t_soft_reset();
    for (int i = 0; i < 8; i++) begin
      wr_reg(`CR_ADDR, 16'h000a);
      wr_reg(`CR_IRQ, 16'h0080);
      wr_reg(`CR_RESET, 16'h0001 << i);
      rd_chk(`SR_ROLE, 16'h0000, 16'hffff);
      rd_chk(`SR_IRQ, 16'h0000, 16'hffff);
    end
    wr_reg(`CR_ADDR, 16'h000a);
    wr_reg(`CR_RESET, 16'h0100);
    rd_chk(`SR_ROLE, 16'h000a, 16'hffff);
  endtask

  task automatic t_decode();
    logic [7:0] b [4] = '{8'h3f, 8'h45, 8'h5f, 8'h26};
    logic [15:0] e [4] = '{16'h0000, 16'h0004, 16'h0000, 16'h0000};
    wr_reg(`CR_ADDR, 16'h0005);
    send_atn(8'h25);
    rd_chk(`SR_XFER, 16'h0002, 16'hffff);
    send_atn(`C_GET);
    send_atn(`C_DCL);
    rd_chk(`SR_EVENTS, 16'h1088, 16'h1088);
    rd_chk(`SR_EVENTS, 16'h0000, 16'hffff);
    for (int i = 0; i < 4; i++) begin
      send_atn(b[i]);
      rd_chk(`SR_XFER, e[i], 16'hffff);
    end
    // Bus clear pulse and a remote line toggle both leave sticky events
    @(posedge clock);
    {tb_ifc, tb_ren} <= 2'b11;
    @(posedge clock);
    {tb_ifc, tb_ren} <= 2'b00;
    rd_chk(`SR_EVENTS, 16'h0201, 16'h0201);
  endtask

  task automatic t_polls();
    wr_reg(`CR_SPOLL, 16'h004a);
    repeat (3) @(posedge clock);
    check({15'h0, srq_oe & srq_out}, 16'h0001);
    send_atn(`C_SPE);
    send_atn(8'h45);
    c0 = pm_cnt;
    {tb_atn, pm_en} <= 2'b01;
    wait_got(c0);
    check({7'h0, pm_atn, pm_byte}, 16'h004a);
    pm_en <= 1'b0;
    rd_chk(`SR_EVENTS, 16'h2400, 16'h2400);
    wr_reg(`CR_PPOLL, 16'h00a5);
    @(posedge clock);
    {tb_atn, tb_eoi} <= 2'b11;
    repeat (2) @(posedge clock);
    check({7'h0, dio_oe, dio_out}, 16'h01a5);
    {tb_atn, tb_eoi} <= 2'b00;
  endtask

  // Six command values go out in order, to a prompt and a slow instrument
  task automatic t_cmd_send();
    wr_reg(`CR_RESET, 16'h0001);
    wr_reg(`CR_ROLE, 16'h0040);
    @(posedge clock);
    pm_en <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      pm_hold <= i[0] ? 4'h3 : 4'h0;
      c0 = pm_cnt;
      wr_reg(`CR_CMD, {8'h00, cmds[i]});
      wait_got(c0);
      check({7'h0, pm_atn, pm_byte}, {8'h01, cmds[i]});
      for (n = 0; n < 300 && dio_oe; n++) @(posedge clock);
      hang(n);
    end
    check({15'h0, pm_slip}, 16'h0000);
    wr_reg(`CR_ROLE, 16'h0000);
    c0 = pm_cnt;
    wr_reg(`CR_CMD, 16'h003f);
    repeat (20) @(posedge clock);
    check(pm_cnt[15:0], c0[15:0]);
    rd_chk(`SR_XFER, 16'h0010, 16'h0010);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {clock, rst_n, wr, rd, tb_atn, tb_dav, tb_eoi, pm_en, tb_ifc, tb_ren} = '0;
    {addr, pm_hold, wdata, tb_dio} = '0;
    {failures, cmp_count} = '0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_registers();
    t_soft_reset();
    t_decode();
    t_polls();
    t_cmd_send();
    wrap_up();
  end
endmodule
